/* hdl/amcr_pkg.sv */
`default_nettype none
package amcr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NCH    = 6;
    localparam int IRQ_W  = 2;

    localparam logic [ADDR_W-1:0] MODE_ADDR     = 8'h02;
    localparam logic [ADDR_W-1:0] CHEN_ADDR     = 8'h03;
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h11;

    localparam logic [DATA_W-1:0] MODE_RESET = 16'h0510;
    localparam logic [DATA_W-1:0] MODE_WMASK = 16'h3f1f;
    localparam logic [NCH-1:0]    CHEN_RESET = 6'h3f;
    localparam int                CHEN_LO    = 8;

    localparam int IRQ_READY = 0;
    localparam int IRQ_APPLY = 1;

    localparam logic [1:0] SRC_LAG = 2'h0;
    localparam logic [1:0] SRC_OR  = 2'h1;

    localparam int CLK_NS    = 20;
    localparam int PULSE_NS  = 80;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        WS_16      = 2'h0,
        WS_24      = 2'h1,
        WS_32_PAD  = 2'h2,
        WS_32_SEXT = 2'h3
    } amcr_wsize_t;

    typedef struct packed {
        logic [1:0]  rsvd_hi;
        logic        reg_crc_en;
        logic        rx_crc_en;
        logic        crc_type;
        logic        reset_seen;
        amcr_wsize_t sample_word_size;
        logic [2:0]  rsvd_lo;
        logic        timeout_en;
        logic [1:0]  ready_pin_source_select;
        logic        ready_pin_idle_float;
        logic        ready_pin_active_format;
    } amcr_mode_t;

    typedef struct packed {
        logic        reg_crc_en;
        logic        rx_crc_en;
        logic        crc_type;
        amcr_wsize_t sample_word_size;
    } amcr_frame_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } amcr_regreq_t;

    function automatic logic wr_hit(input amcr_regreq_t q, input logic [ADDR_W-1:0] a);
        return q.wr && (q.addr == a);
    endfunction : wr_hit

endpackage : amcr_pkg
`default_nettype wire

/* hdl/amcr_word_fmt.sv */
`default_nettype none
module amcr_word_fmt (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire amcr_pkg::amcr_wsize_t word_size,
    input  wire logic [23:0]           sample_in,
    input  wire logic                  sample_valid,
    output logic [31:0]                word_out,
    output logic                       word_valid
);
    import amcr_pkg::*;

    // output word is left aligned with unused low bits zero, except WS_32_SEXT: right aligned, sign extended into the top byte
    always_ff @(posedge mclk) begin
        if (rst) begin
            word_out <= 32'h0000_0000;
        end else if (sample_valid) begin
            case (word_size)
                WS_16:      word_out <= {sample_in[23:8], 16'h0000};
                WS_24:      word_out <= {sample_in, 8'h00};
                WS_32_PAD:  word_out <= {sample_in, 8'h00};
                WS_32_SEXT: word_out <= {{8{sample_in[23]}}, sample_in};
                default:    word_out <= {sample_in, 8'h00};
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            word_valid <= 1'b0;
        end else begin
            word_valid <= sample_valid;
        end
    end

    a_pad_low_zero: assert property (@(posedge mclk) disable iff (rst)
        sample_valid && word_size == WS_32_PAD |=> word_out[7:0] == 8'h00 && word_out[31:8] == $past(sample_in))
        else $error("zero padding format wrong");

    a_sign_ext_top: assert property (@(posedge mclk) disable iff (rst)
        sample_valid && word_size == WS_32_SEXT |=> word_out[31:24] == {8{$past(sample_in[23])}})
        else $error("sign extension format wrong");

endmodule : amcr_word_fmt
`default_nettype wire

/* hdl/amcr_ready_pin.sv */
`default_nettype none
module amcr_ready_pin (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic active,
    input  wire logic active_format,
    input  wire logic idle_float,
    output logic      pin_out,
    output logic      pin_oe_n
);
    import amcr_pkg::*;

    typedef enum logic [3:0] {
        PIN_IDLE  = 4'b0001,
        PIN_PULSE = 4'b0010,
        PIN_HOLD  = 4'b0100,
        PIN_DONE  = 4'b1000
    } amcr_pin_state_t;

    amcr_pin_state_t st_ff;
    amcr_pin_state_t nxt_st;
    logic [7:0]      cnt_ff;
    logic            drive_low;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            PIN_IDLE:  if (active) nxt_st = active_format ? PIN_PULSE : PIN_HOLD;
            PIN_PULSE: if (cnt_ff == 8'(PULSE_CYC - 1)) nxt_st = PIN_DONE;
            PIN_HOLD:  if (!active) nxt_st = PIN_IDLE;
            PIN_DONE:  if (!active) nxt_st = PIN_IDLE;
            default:   nxt_st = PIN_IDLE;
        endcase
    end

    assign drive_low = (nxt_st == PIN_PULSE) || (nxt_st == PIN_HOLD);

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= PIN_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || st_ff != PIN_PULSE) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // idle level is high or released; oe_n low means driven
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_out  <= 1'b1;
            pin_oe_n <= 1'b0;
        end else begin
            pin_out  <= !drive_low;
            pin_oe_n <= !drive_low && idle_float;
        end
    end

    sequence s_pulse_low;
        (!pin_out && !pin_oe_n) [*4];
    endsequence

    sequence s_released;
        pin_out;
    endsequence

    a_pulse_length: assert property (@(posedge mclk) disable iff (rst)
        st_ff == PIN_IDLE && active && active_format |=> s_pulse_low ##1 s_released)
        else $error("ready pulse length wrong");

    a_level_low: assert property (@(posedge mclk) disable iff (rst)
        st_ff != PIN_PULSE && st_ff != PIN_DONE && active && !active_format |=> !pin_out && !pin_oe_n)
        else $error("ready level not low");

    a_idle_state: assert property (@(posedge mclk) disable iff (rst)
        st_ff != PIN_PULSE && !active |=> pin_out && (pin_oe_n == $past(idle_float)))
        else $error("ready idle state wrong");

endmodule : amcr_ready_pin
`default_nettype wire

/* hdl/amcr_top.sv */
// The implementer's own choices: the placing of the registers and strobed register access.
`default_nettype none
module amcr_top (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire amcr_pkg::amcr_regreq_t    reg_req,
    output logic [amcr_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic [amcr_pkg::NCH-1:0]  chan_ready,
    input  wire logic                      frame_done,
    input  wire logic [23:0]               sample_in,
    input  wire logic                      sample_valid,
    output logic [31:0]                    word_out,
    output logic                           word_valid,
    output amcr_pkg::amcr_frame_cfg_t      frame_cfg,
    output logic                           timeout_en,
    output logic                           data_ready_pin,
    output logic                           data_ready_pin_oe_n,
    output logic                           irq
);
    import amcr_pkg::*;

    localparam amcr_mode_t MODE_RST_T = amcr_mode_t'(MODE_RESET);

    localparam amcr_frame_cfg_t CFG_RESET = '{
        reg_crc_en:       MODE_RST_T.reg_crc_en,
        rx_crc_en:        MODE_RST_T.rx_crc_en,
        crc_type:         MODE_RST_T.crc_type,
        sample_word_size: MODE_RST_T.sample_word_size
    };

    amcr_mode_t      mode_ff;
    amcr_mode_t      nxt_mode;
    amcr_mode_t      wr_mode;
    logic [NCH-1:0]  chan_en_ff;
    logic [NCH-1:0]  chan_lvl_ff;
    logic [NCH-1:0]  chan_flag_ff;
    logic [NCH-1:0]  nxt_chan_flag;
    logic [NCH-1:0]  live_en;
    logic [NCH-1:0]  flag_en;
    logic            all_lagging;
    logic            src_active;
    logic            ready_active_ff;
    amcr_frame_cfg_t frame_cfg_ff;
    amcr_frame_cfg_t staged_cfg;
    logic            timeout_en_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;
    logic            irq_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    // mode register

    assign wr_mode = amcr_mode_t'(reg_req.wdata & MODE_WMASK);

    always_comb begin
        nxt_mode = mode_ff;
        if (wr_hit(reg_req, MODE_ADDR)) begin
            nxt_mode            = wr_mode;
            nxt_mode.reset_seen = mode_ff.reset_seen & wr_mode.reset_seen;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_ff <= MODE_RST_T;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // channel enables

    always_ff @(posedge mclk) begin
        if (rst) begin
            chan_en_ff <= CHEN_RESET;
        end else if (wr_hit(reg_req, CHEN_ADDR)) begin
            chan_en_ff <= reg_req.wdata[CHEN_LO +: NCH];
        end
    end

    // per-channel new data flags, cleared when a frame has carried them out

    always_ff @(posedge mclk) begin
        if (rst) begin
            chan_lvl_ff <= '0;
        end else begin
            chan_lvl_ff <= chan_ready;
        end
    end

    always_comb begin
        nxt_chan_flag = frame_done ? '0 : chan_flag_ff;
        nxt_chan_flag = nxt_chan_flag | (chan_ready & ~chan_lvl_ff);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            chan_flag_ff <= '0;
        end else begin
            chan_flag_ff <= nxt_chan_flag;
        end
    end

    // ready source selection

    assign live_en     = chan_ready & chan_en_ff;
    assign flag_en     = chan_flag_ff & chan_en_ff;
    assign all_lagging = (chan_en_ff != '0) && ((chan_flag_ff | ~chan_en_ff) == '1);

    always_comb begin
        case (mode_ff.ready_pin_source_select)
            SRC_LAG: src_active = all_lagging;
            SRC_OR:  src_active = |live_en;
            default: src_active = |flag_en;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ready_active_ff <= 1'b0;
        end else begin
            ready_active_ff <= src_active;
        end
    end

    amcr_ready_pin u_ready_pin (
        .mclk          (mclk),
        .rst           (rst),
        .active        (ready_active_ff),
        .active_format (mode_ff.ready_pin_active_format),
        .idle_float    (mode_ff.ready_pin_idle_float),
        .pin_out       (data_ready_pin),
        .pin_oe_n      (data_ready_pin_oe_n)
    );

    // frame settings: staged here, taken at the frame boundary; timeout_en follows the mode register one cycle later

    assign staged_cfg = '{
        reg_crc_en:       mode_ff.reg_crc_en,
        rx_crc_en:        mode_ff.rx_crc_en,
        crc_type:         mode_ff.crc_type,
        sample_word_size: mode_ff.sample_word_size
    };

    always_ff @(posedge mclk) begin
        if (rst) begin
            frame_cfg_ff <= CFG_RESET;
        end else if (frame_done) begin
            frame_cfg_ff <= staged_cfg;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            timeout_en_ff <= MODE_RST_T.timeout_en;
        end else begin
            timeout_en_ff <= mode_ff.timeout_en;
        end
    end

    amcr_word_fmt u_word_fmt (
        .mclk         (mclk),
        .rst          (rst),
        .word_size    (frame_cfg_ff.sample_word_size),
        .sample_in    (sample_in),
        .sample_valid (sample_valid),
        .word_out     (word_out),
        .word_valid   (word_valid)
    );

    // interrupt status, write one to clear, a new event wins

    always_comb begin
        irq_event            = '0;
        irq_event[IRQ_READY] = src_active && !ready_active_ff;
        irq_event[IRQ_APPLY] = frame_done && (staged_cfg != frame_cfg_ff);
    end

    assign irq_clr = wr_hit(reg_req, IRQ_STAT_ADDR) ? reg_req.wdata[IRQ_W-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_event;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_mask_ff <= '0;
        end else if (wr_hit(reg_req, IRQ_MASK_ADDR)) begin
            irq_mask_ff <= reg_req.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // read port: data stand only in the cycle after the strobe

    always_comb begin
        nxt_rdata = '0;
        if (reg_req.rd) begin
            case (reg_req.addr)
                MODE_ADDR:     nxt_rdata = mode_ff & MODE_WMASK;
                CHEN_ADDR:     nxt_rdata = DATA_W'(chan_en_ff) << CHEN_LO;
                IRQ_STAT_ADDR: nxt_rdata = DATA_W'(irq_stat_ff);
                IRQ_MASK_ADDR: nxt_rdata = DATA_W'(irq_mask_ff);
                default:       nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign frame_cfg  = frame_cfg_ff;
    assign timeout_en = timeout_en_ff;
    assign irq        = irq_ff;

    // checks

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    sequence s_mode_write(logic [DATA_W-1:0] d);
        reg_req.wr && reg_req.addr == MODE_ADDR && reg_req.wdata == d;
    endsequence

    sequence s_mode_read;
        reg_req.rd && reg_req.addr == MODE_ADDR;
    endsequence

    a_mode_reset_val: assert property (@(posedge mclk) disable iff (1'b0)
        rst ##1 (!rst && !reg_req.wr && !reg_req.rd) ##1 s_mode_read |=> reg_rdata == MODE_RESET)
        else $error("mode register reset value wrong");

    a_reset_flag_clear: assert property (
        reg_req.wr && reg_req.addr == MODE_ADDR && !reg_req.wdata[10] |=> !mode_ff.reset_seen)
        else $error("reset flag not cleared");

    a_reset_flag_keep: assert property (
        mode_ff.reset_seen && !(reg_req.wr && reg_req.addr == MODE_ADDR && !reg_req.wdata[10])
        |=> mode_ff.reset_seen)
        else $error("reset flag lost");

    a_reset_flag_nosat: assert property (
        !mode_ff.reset_seen |=> !mode_ff.reset_seen)
        else $error("reset flag set by a write");

    a_reserved_zero: assert property (
        s_mode_read |=> reg_rdata[15:14] == 2'h0 && reg_rdata[7:5] == 3'h0)
        else $error("reserved bits not zero");

    a_write_readback: assert property (
        s_mode_write(16'hffff) ##1 !reg_req.wr ##1 s_mode_read
        |=> reg_rdata == (MODE_WMASK & ~16'h0400 | {5'h0, $past(mode_ff.reset_seen, 3), 10'h0}))
        else $error("mode readback wrong");

    a_cfg_hold: assert property (
        !frame_done |=> $stable(frame_cfg_ff))
        else $error("frame settings changed inside a frame");

    a_cfg_apply: assert property (
        frame_done |=> frame_cfg_ff.sample_word_size == $past(mode_ff.sample_word_size))
        else $error("word length not applied at frame end");

    a_crc_apply: assert property (
        frame_done |=> frame_cfg_ff.reg_crc_en == $past(mode_ff.reg_crc_en)
            && frame_cfg_ff.rx_crc_en == $past(mode_ff.rx_crc_en)
            && frame_cfg_ff.crc_type == $past(mode_ff.crc_type))
        else $error("checksum settings not applied");

    a_timeout_follow: assert property (
        reg_req.wr && reg_req.addr == MODE_ADDR |=> ##1 timeout_en == $past(reg_req.wdata[4], 2))
        else $error("timeout enable not followed");

    a_lagging_src: assert property (
        mode_ff.ready_pin_source_select == SRC_LAG && !all_lagging |=> !ready_active_ff)
        else $error("lagging source asserted early");

    a_disabled_chan: assert property (
        chan_en_ff == '0 |=> !ready_active_ff)
        else $error("ready with no channel enabled");

    a_irq_w1c: assert property (
        irq_stat_ff[IRQ_READY] && irq_clr[IRQ_READY] && !irq_event[IRQ_READY]
        |=> !irq_stat_ff[IRQ_READY])
        else $error("status bit not cleared");

    a_irq_out: assert property (
        (irq_stat_ff & irq_mask_ff) != '0 |=> irq)
        else $error("interrupt not raised");

endmodule : amcr_top
`default_nettype wire

/* tb/amcr_far_model.sv */
`default_nettype none
module amcr_far_model (
    input  wire logic  mclk,
    output logic [5:0]  chan_ready,
    output logic        frame_done,
    output logic [23:0] sample_in,
    output logic        sample_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chan_ready   = 6'h00;
        frame_done   = 1'b0;
        sample_in    = 24'h000000;
        sample_valid = 1'b0;
    end
    // per-channel result levels
    task automatic ready(input logic [5:0] m);
        @(posedge mclk);
        chan_ready <= m;
    endtask : ready
    // one-cycle end-of-frame strobe
    task automatic frame();
        @(posedge mclk);
        frame_done <= 1'b1;
        @(posedge mclk);
        frame_done <= 1'b0;
    endtask : frame
    // data line shows the inverse once the strobe is gone
    task automatic sample(input logic [23:0] s);
        @(posedge mclk);
        sample_in    <= s;
        sample_valid <= 1'b1;
        @(posedge mclk);
        sample_in    <= ~s;
        sample_valid <= 1'b0;
    endtask : sample
endmodule : amcr_far_model
`default_nettype wire

/* tb/test_amcr_top.sv */
`default_nettype none
module test_amcr_top;
    import amcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  mclk;
    logic                  rst;
    amcr_regreq_t          reg_req;
    logic [DATA_W-1:0]     reg_rdata;
    logic [NCH-1:0]        chan_ready;
    logic                  frame_done;
    logic [23:0]           sample_in;
    logic                  sample_valid;
    logic [31:0]           word_out;
    logic                  word_valid;
    amcr_frame_cfg_t       frame_cfg;
    logic                  timeout_en;
    logic                  data_ready_pin;
    logic                  data_ready_pin_oe_n;
    logic                  irq;
    int                    mismatches;
    int                    num_checks;
    logic [DATA_W-1:0]     rd_v;

    amcr_top DUT (
        .mclk                (mclk),
        .rst                 (rst),
        .reg_req             (reg_req),
        .reg_rdata           (reg_rdata),
        .chan_ready          (chan_ready),
        .frame_done          (frame_done),
        .sample_in           (sample_in),
        .sample_valid        (sample_valid),
        .word_out            (word_out),
        .word_valid          (word_valid),
        .frame_cfg           (frame_cfg),
        .timeout_en          (timeout_en),
        .data_ready_pin      (data_ready_pin),
        .data_ready_pin_oe_n (data_ready_pin_oe_n),
        .irq                 (irq)
    );
    amcr_far_model far (
        .mclk         (mclk),
        .chan_ready   (chan_ready),
        .frame_done   (frame_done),
        .sample_in    (sample_in),
        .sample_valid (sample_valid)
    );

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        reg_req <= '0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        rd(a, rd_v);
        chk(what, {16'h0000, exp}, {16'h0000, rd_v});
    endtask : rd_chk
    // waits a bounded number of cycles for the pin to reach a level
    task automatic wait_pin(input logic lvl, input int lim);
        int n;
        n = 0;
        while (data_ready_pin !== lvl && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("pin level", {31'h0, lvl}, {31'h0, data_ready_pin});
    endtask : wait_pin

    task automatic t_reset();
        rd_chk("mode reset", MODE_ADDR, 16'h0510);
        rd_chk("chan enable reset", CHEN_ADDR, 16'h3f00);
        rd_chk("unmapped read", 8'h7e, 16'h0000);
        chk("frame cfg reset", 32'h01, {27'h0, frame_cfg});
        chk("timeout reset", 32'h1, {31'h0, timeout_en});
        chk("pin idle", 32'h1, {31'h0, data_ready_pin});
        chk("pin driven", 32'h0, {31'h0, data_ready_pin_oe_n});
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        wr(MODE_ADDR, 16'hffff);
        rd_chk("mode all ones", MODE_ADDR, 16'h3f1f);
        repeat (2) @(posedge mclk);
        chk("timeout follows", 32'h1, {31'h0, timeout_en});
        wr(MODE_ADDR, 16'h0000);
        rd_chk("mode zero", MODE_ADDR, 16'h0000);
        repeat (2) @(posedge mclk);
        chk("timeout off", 32'h0, {31'h0, timeout_en});
        wr(MODE_ADDR, 16'h0400);
        rd_chk("reset flag stays clear", MODE_ADDR, 16'h0000);
        wr(8'h7e, 16'hffff);
        rd_chk("unmapped write", MODE_ADDR, 16'h0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_frame();
        wr(IRQ_STAT_ADDR, 16'h0003);
        far.frame();
        wr(MODE_ADDR, 16'h3a00);
        #1;
        chk("cfg before frame", 32'h00, {27'h0, frame_cfg});
        far.frame();
        #1;
        chk("cfg after frame", 32'h1e, {27'h0, frame_cfg});
        rd_chk("cfg change status", IRQ_STAT_ADDR, 16'h0002);
        wr(IRQ_MASK_ADDR, 16'h0002);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq on", 32'h1, {31'h0, irq});
        wr(IRQ_STAT_ADDR, 16'h0002);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        fork
            wr(MODE_ADDR, 16'h0000);
            far.frame();
        join
        #1;
        chk("same cycle write", 32'h1e, {27'h0, frame_cfg});
        far.frame();
        #1;
        chk("next frame", 32'h00, {27'h0, frame_cfg});
        wr(IRQ_MASK_ADDR, 16'h0000);
        $display("test frame done");
    endtask : t_frame
    task automatic t_words();
        logic [23:0] s;
        logic [31:0] e[4];
        s = 24'h8a5c3e;
        e[0] = {s[23:8], 16'h0000};
        e[1] = {s, 8'h00};
        e[2] = {s, 8'h00};
        e[3] = {{8{s[23]}}, s};
        for (int c = 0; c < 4; c++) begin
            wr(MODE_ADDR, {6'h00, 2'(c), 8'h00});
            far.frame();
            far.sample(s);
            #1;
            chk("word valid", 32'h1, {31'h0, word_valid});
            chk("word out", e[c], word_out);
        end
        $display("test words done");
    endtask : t_words
    task automatic t_pin();
        int lows;
        wr(IRQ_STAT_ADDR, 16'h0003);
        wr(MODE_ADDR, 16'h0004);
        far.ready(6'h01);
        @(posedge mclk);
        #1;
        chk("pin before lag", 32'h1, {31'h0, data_ready_pin});
        @(posedge mclk);
        #1;
        chk("pin level low", 32'h0, {31'h0, data_ready_pin});
        rd_chk("ready status", IRQ_STAT_ADDR, 16'h0001);
        wr(IRQ_MASK_ADDR, 16'h0001);
        repeat (2) @(posedge mclk);
        #1;
        chk("ready irq", 32'h1, {31'h0, irq});
        wr(IRQ_STAT_ADDR, 16'h0003);
        far.ready(6'h00);
        wait_pin(1'b1, 3);
        chk("irq after clear", 32'h0, {31'h0, irq});
        wr(MODE_ADDR, 16'h0005);
        far.ready(6'h01);
        lows = 0;
        repeat (12) begin
            @(posedge mclk);
            #1;
            if (data_ready_pin === 1'b0) lows++;
        end
        chk("pulse length", PULSE_CYC, lows);
        wr(MODE_ADDR, 16'h0006);
        far.ready(6'h00);
        repeat (3) @(posedge mclk);
        #1;
        chk("idle float", 32'h1, {31'h0, data_ready_pin_oe_n});
        wr(CHEN_ADDR, 16'h0300);
        wr(MODE_ADDR, 16'h0000);
        far.frame();
        far.ready(6'h3d);
        repeat (5) @(posedge mclk);
        #1;
        chk("lag waits", 32'h1, {31'h0, data_ready_pin});
        far.ready(6'h3f);
        wait_pin(1'b0, 6);
        far.ready(6'h00);
        wr(MODE_ADDR, 16'h0008);
        far.frame();
        wait_pin(1'b1, 6);
        far.ready(6'h02);
        wait_pin(1'b0, 6);
        far.ready(6'h00);
        wr(MODE_ADDR, 16'h000c);
        far.frame();
        wait_pin(1'b1, 6);
        far.ready(6'h01);
        wait_pin(1'b0, 6);
        wr(CHEN_ADDR, 16'h0000);
        wait_pin(1'b1, 6);
        rd_chk("chan enable off", CHEN_ADDR, 16'h0000);
        $display("test pin done");
    endtask : t_pin

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        close_out();
    end
    initial begin
        mismatches = 0;
        num_checks = 0;
        rst        = 1'b1;
        reg_req    = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_frame();
        t_words();
        t_pin();
        close_out();
    end
endmodule : test_amcr_top
`default_nettype wire
